// File: rtl/sdcsc_ctrl.sv
`timescale 1ns/1ps
module sdcsc_ctrl import sdcsc_pkg::*; #(
    parameter int BURST_CLKS = SDCSC_BURST_CLKS,
    parameter int XSNR_CLKS = SDCSC_XSNR_CLKS,
    parameter int XSRD_CLKS = SDCSC_XSRD_CLKS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sdcsc_if.ctrl_end pins,
    input wire logic req_valid,
    input sdcsc_cmd_t req_cmd,
    input wire logic [SDCSC_BANK_W-1:0] req_bank,
    input wire logic [SDCSC_ADDR_W-1:0] req_addr,
    input wire logic [2*SDCSC_DATA_W-1:0] req_wdata,
    input wire logic [2*SDCSC_MASK_W-1:0] req_wmask,
    input wire logic odt_level,
    input wire logic calib_active,
    output logic req_ready,
    output logic req_done,
    output logic req_error,
    output logic low_power
);

    // ========================================
    // State
    logic cke_reg, cke_next;
    logic sr_reg, sr_next;
    logic [2:0] rcw_reg, rcw_next;
    logic cs_n_reg, cs_n_next;
    logic [SDCSC_BANK_W-1:0] bank_reg, bank_next;
    logic [SDCSC_ADDR_W-1:0] addr_reg, addr_next;
    logic odt_reg, odt_next;
    logic dqs_reg, dqs_next;
    logic [SDCSC_DATA_W-1:0] dq_reg, dq_next;
    logic [SDCSC_MASK_W-1:0] dm_reg, dm_next;
    logic [2*SDCSC_DATA_W-1:0] wbuf_reg, wbuf_next;
    logic [2*SDCSC_MASK_W-1:0] mbuf_reg, mbuf_next;
    logic wdir_reg, wdir_next;
    logic [SDCSC_CNT_W-1:0] beat_reg, beat_next;
    logic [SDCSC_CNT_W-1:0] hold_reg, hold_next;
    logic [SDCSC_CNT_W-1:0] xsnr_reg, xsnr_next;
    logic [SDCSC_CNT_W-1:0] xsrd_reg, xsrd_next;
    logic [SDCSC_NUM_BANKS-1:0] open_reg, open_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic lp_reg, lp_next;
    logic take;
    logic ok;

    // ========================================
    // Next state
    always_comb begin
        cke_next = cke_reg;
        sr_next = sr_reg;
        rcw_next = SDCSC_RCW_NOP;
        cs_n_next = 1'b0;
        bank_next = bank_reg;
        addr_next = addr_reg;
        odt_next = odt_level;
        dqs_next = 1'b0;
        dq_next = '0;
        dm_next = '1;
        wbuf_next = wbuf_reg;
        mbuf_next = mbuf_reg;
        wdir_next = wdir_reg;
        beat_next = beat_reg;
        hold_next = (hold_reg != '0) ? hold_reg - 1'b1 : '0;
        xsnr_next = (xsnr_reg != '0) ? xsnr_reg - 1'b1 : '0;
        xsrd_next = (xsrd_reg != '0) ? xsrd_reg - 1'b1 : '0;
        open_next = open_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        take = req_valid && ready_reg;
        ok = 1'b0;

        if (beat_reg != '0) begin
            beat_next = beat_reg - 1'b1;
            if (wdir_reg) begin
                dqs_next = 1'b1;
                dq_next = wbuf_reg[SDCSC_DATA_W-1:0];
                dm_next = mbuf_reg[SDCSC_MASK_W-1:0];
                wbuf_next = wbuf_reg >> SDCSC_DATA_W;
                mbuf_next = mbuf_reg >> SDCSC_MASK_W;
            end
        end

        if (take) begin
            if (!cke_reg) begin
                ok = (req_cmd == (sr_reg ? CMD_SR_EXIT : CMD_PD_EXIT));
                if (ok) begin
                    cke_next = 1'b1;
                    sr_next = 1'b0;
                    if (sr_reg) begin
                        xsnr_next = SDCSC_CNT_W'(XSNR_CLKS);
                        xsrd_next = SDCSC_CNT_W'(XSRD_CLKS);
                    end
                end
            end else if (req_cmd == CMD_PD_ENTER || req_cmd == CMD_SR_ENTER) begin
                ok = !calib_active && (req_cmd == CMD_PD_ENTER || open_reg == '0);
                if (ok) begin
                    cke_next = 1'b0;
                    sr_next = (req_cmd == CMD_SR_ENTER);
                    if (req_cmd == CMD_SR_ENTER) begin
                        rcw_next = SDCSC_RCW_REF;
                    end
                end
            end else begin
                ok = sdcsc_cmd_legal(req_cmd, |open_reg, 1'b0, 1'b0) &&
                     !(req_cmd == CMD_READ && xsrd_reg != '0);
                if (ok) begin
                    bank_next = req_bank;
                    addr_next = req_addr;
                    case (req_cmd)
                        CMD_ACT: begin
                            rcw_next = SDCSC_RCW_ACT;
                            open_next[req_bank] = 1'b1;
                        end
                        CMD_PRE: begin
                            rcw_next = SDCSC_RCW_PRE;
                            if (req_addr[SDCSC_AUTO_CLOSE_BIT]) begin
                                open_next = '0;
                            end else begin
                                open_next[req_bank] = 1'b0;
                            end
                        end
                        CMD_READ, CMD_WRITE: begin
                            rcw_next = (req_cmd == CMD_READ) ? SDCSC_RCW_READ : SDCSC_RCW_WRITE;
                            wdir_next = (req_cmd == CMD_WRITE);
                            beat_next = SDCSC_CNT_W'(BURST_CLKS);
                            wbuf_next = req_wdata;
                            mbuf_next = req_wmask;
                            if (req_addr[SDCSC_AUTO_CLOSE_BIT]) begin
                                open_next[req_bank] = 1'b0;
                            end
                        end
                        CMD_REF: rcw_next = SDCSC_RCW_REF;
                        CMD_MRS: rcw_next = SDCSC_RCW_MRS;
                        default: rcw_next = SDCSC_RCW_NOP;
                    endcase
                end
            end
            done_next = ok;
            err_next = !ok;
            if (cke_next != cke_reg) begin
                hold_next = SDCSC_CNT_W'(SDCSC_MIN_GATE_HOLD_CLKS - 1);
            end
        end
        // Busy burst, gate hold or exit delay blocks the next request
        ready_next = (beat_next == '0) && (hold_next == '0) && (xsnr_next == '0);
        lp_next = !cke_next;
    end

    // ========================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cke_reg <= SDCSC_CKE_RESET;
            sr_reg <= 1'b0;
            rcw_reg <= SDCSC_RCW_NOP;
            cs_n_reg <= 1'b1;
            bank_reg <= '0;
            addr_reg <= '0;
            odt_reg <= 1'b0;
            dqs_reg <= 1'b0;
            dq_reg <= '0;
            dm_reg <= '1;
            wbuf_reg <= '0;
            mbuf_reg <= '1;
            wdir_reg <= 1'b0;
            beat_reg <= '0;
            hold_reg <= '0;
            xsnr_reg <= '0;
            xsrd_reg <= '0;
            open_reg <= '0;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            lp_reg <= !SDCSC_CKE_RESET;
        end else begin
            cke_reg <= cke_next;
            sr_reg <= sr_next;
            rcw_reg <= rcw_next;
            cs_n_reg <= cs_n_next;
            bank_reg <= bank_next;
            addr_reg <= addr_next;
            odt_reg <= odt_next;
            dqs_reg <= dqs_next;
            dq_reg <= dq_next;
            dm_reg <= dm_next;
            wbuf_reg <= wbuf_next;
            mbuf_reg <= mbuf_next;
            wdir_reg <= wdir_next;
            beat_reg <= beat_next;
            hold_reg <= hold_next;
            xsnr_reg <= xsnr_next;
            xsrd_reg <= xsrd_next;
            open_reg <= open_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            err_reg <= err_next;
            lp_reg <= lp_next;
        end
    end

    assign pins.clock_gate_input = cke_reg;
    assign pins.chip_select_n = cs_n_reg;
    assign pins.row_strobe_n = rcw_reg[2];
    assign pins.column_strobe_n = rcw_reg[1];
    assign pins.write_enable_n = rcw_reg[0];
    assign pins.group_select = bank_reg;
    assign pins.address = addr_reg;
    assign pins.termination_enable = odt_reg;
    assign pins.data = dq_reg;
    assign pins.data_strobe = dqs_reg;
    assign pins.write_byte_mask = dm_reg;
    assign req_ready = ready_reg;
    assign req_done = done_reg;
    assign req_error = err_reg;
    assign low_power = lp_reg;

endmodule : sdcsc_ctrl

// File: rtl/sdcsc_device.sv
// What this block does
// - Transition from previous gate, present gate, command
// - Gate fall with NOP enters power down
// - Gate fall with refresh enters self refresh
// - Self refresh holds low, exits on NOP rise
// - Controller waits exit delay before commands, refuses reads with an error until read delay ends
// - No power down during busy operations
// - Gate held three edges after each change
// - Gate high: only legal commands issued
// - Unlisted combinations flagged illegal
// - Termination ignored for transitions, off in self refresh
// - Termination driven valid during power down
// - No internal refresh in power down
// - Gate kept high during driver calibration
// - Mask low writes beat, high inhibits
// - Idle state command responses
// - Banks active state command responses
// - Burst continues, same direction interrupts
// - Power down exit on gate high NOP
// - Burst length four never interrupted
// - Commands decoded from strobes at rising edge
`timescale 1ns/1ps
module sdcsc_device import sdcsc_pkg::*; #(
    parameter int BURST_CLKS = SDCSC_BURST_CLKS,
    parameter int SR_TICK_CLKS = SDCSC_SR_TICK_CLKS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    sdcsc_if.device_end pins,
    output logic [SDCSC_DATA_W-1:0] wr_data,
    output logic [SDCSC_MASK_W-1:0] wr_byte_en,
    output logic wr_valid,
    output logic read_beat,
    output logic illegal_cmd,
    output logic power_down,
    output logic self_refresh,
    output logic odt_active,
    output logic sr_refresh_tick,
    output logic [SDCSC_NUM_BANKS-1:0] open_banks
);

    typedef enum logic [2:0] {
        D_IDLE, D_ACTIVE, D_READ, D_WRITE, D_PD_PRE, D_PD_ACT, D_SELF_REF
    } sdcsc_dstate_t;

    // ========================================
    // State
    sdcsc_dstate_t state_reg, state_next;
    logic cke_prev_reg, cke_prev_next;
    logic [SDCSC_NUM_BANKS-1:0] open_reg, open_next;
    logic [SDCSC_CNT_W-1:0] beat_reg, beat_next;
    logic [SDCSC_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic auto_close_reg, auto_close_next;
    logic [SDCSC_BANK_W-1:0] burst_bank_reg, burst_bank_next;
    logic illegal_reg, illegal_next;
    logic rd_beat_reg, rd_beat_next;
    logic wr_valid_reg, wr_valid_next;
    logic [SDCSC_DATA_W-1:0] wr_data_reg, wr_data_next;
    logic [SDCSC_MASK_W-1:0] wr_be_reg, wr_be_next;
    logic odt_reg, odt_next;
    logic tick_reg, tick_next;
    logic pd_reg, pd_next;
    logic sref_reg, sref_next;

    sdcsc_cmd_t cmd;
    logic cke_now;
    logic any_open;
    logic in_read;
    logic in_write;

    // ========================================
    // Decode
    always_comb begin
        cmd = sdcsc_decode(pins.chip_select_n, {pins.row_strobe_n, pins.column_strobe_n,
                                                pins.write_enable_n});
        cke_now = pins.clock_gate_input;
        any_open = |open_reg;
        in_read = (state_reg == D_READ);
        in_write = (state_reg == D_WRITE);
    end

    // ========================================
    // Next state
    always_comb begin
        state_next = state_reg;
        cke_prev_next = cke_now;
        open_next = open_reg;
        beat_next = beat_reg;
        tick_cnt_next = '0;
        tick_next = 1'b0;
        auto_close_next = auto_close_reg;
        burst_bank_next = burst_bank_reg;
        illegal_next = 1'b0;
        rd_beat_next = 1'b0;
        wr_valid_next = 1'b0;
        wr_data_next = wr_data_reg;
        wr_be_next = '0;
        odt_next = pins.termination_enable && (state_reg != D_SELF_REF);

        unique case (state_reg)
            D_PD_PRE, D_PD_ACT: begin
                if (cke_now) begin
                    if (cmd == CMD_NOP) begin
                        state_next = (state_reg == D_PD_ACT) ? D_ACTIVE : D_IDLE;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end
            end
            D_SELF_REF: begin
                if (cke_now) begin
                    if (cmd == CMD_NOP) begin
                        state_next = D_IDLE;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end else if (tick_cnt_reg == SDCSC_CNT_W'(SR_TICK_CLKS - 1)) begin
                    tick_next = 1'b1;
                end else begin
                    tick_cnt_next = tick_cnt_reg + 1'b1;
                end
            end
            default: begin
                if (in_read || in_write) begin
                    if (in_read) begin
                        rd_beat_next = 1'b1;
                    end
                    if (in_write && pins.data_strobe) begin
                        wr_valid_next = |(~pins.write_byte_mask);
                        wr_be_next = ~pins.write_byte_mask;
                        wr_data_next = pins.data;
                    end
                end
                if (!cke_prev_reg) begin
                    illegal_next = 1'b1;
                end else if (!cke_now) begin
                    if (cmd == CMD_NOP && !in_read && !in_write) begin
                        state_next = any_open ? D_PD_ACT : D_PD_PRE;
                    end else if (cmd == CMD_REF && state_reg == D_IDLE) begin
                        state_next = D_SELF_REF;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end else if (!sdcsc_cmd_legal(cmd, any_open, in_read, in_write)) begin
                    illegal_next = 1'b1;
                end else begin
                    case (cmd)
                        CMD_ACT: begin
                            open_next[pins.group_select] = 1'b1;
                            state_next = D_ACTIVE;
                        end
                        CMD_PRE: begin
                            if (pins.address[SDCSC_AUTO_CLOSE_BIT]) begin
                                open_next = '0;
                            end else begin
                                open_next[pins.group_select] = 1'b0;
                            end
                            state_next = (open_next == '0) ? D_IDLE : D_ACTIVE;
                        end
                        CMD_READ, CMD_WRITE: begin
                            state_next = (cmd == CMD_READ) ? D_READ : D_WRITE;
                            beat_next = SDCSC_CNT_W'(BURST_CLKS - 1);
                            auto_close_next = pins.address[SDCSC_AUTO_CLOSE_BIT];
                            burst_bank_next = pins.group_select;
                        end
                        CMD_NOP: begin
                            if (in_read || in_write) begin
                                if (beat_reg == '0) begin
                                    if (auto_close_reg) begin
                                        open_next[burst_bank_reg] = 1'b0;
                                    end
                                    state_next = (open_next == '0) ? D_IDLE : D_ACTIVE;
                                end else begin
                                    beat_next = beat_reg - 1'b1;
                                end
                            end
                        end
                        default: begin
                            // Refresh and mode register set complete outside this block
                            state_next = D_IDLE;
                        end
                    endcase
                end
            end
        endcase
        pd_next = (state_next == D_PD_PRE) || (state_next == D_PD_ACT);
        sref_next = (state_next == D_SELF_REF);
    end

    // ========================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= D_IDLE;
            cke_prev_reg <= SDCSC_CKE_RESET;
            open_reg <= '0;
            beat_reg <= '0;
            tick_cnt_reg <= '0;
            auto_close_reg <= 1'b0;
            burst_bank_reg <= '0;
            illegal_reg <= 1'b0;
            rd_beat_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_data_reg <= '0;
            wr_be_reg <= '0;
            odt_reg <= 1'b0;
            tick_reg <= 1'b0;
            pd_reg <= 1'b0;
            sref_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cke_prev_reg <= cke_prev_next;
            open_reg <= open_next;
            beat_reg <= beat_next;
            tick_cnt_reg <= tick_cnt_next;
            auto_close_reg <= auto_close_next;
            burst_bank_reg <= burst_bank_next;
            illegal_reg <= illegal_next;
            rd_beat_reg <= rd_beat_next;
            wr_valid_reg <= wr_valid_next;
            wr_data_reg <= wr_data_next;
            wr_be_reg <= wr_be_next;
            odt_reg <= odt_next;
            tick_reg <= tick_next;
            pd_reg <= pd_next;
            sref_reg <= sref_next;
        end
    end

    assign wr_data = wr_data_reg;
    assign wr_byte_en = wr_be_reg;
    assign wr_valid = wr_valid_reg;
    assign read_beat = rd_beat_reg;
    assign illegal_cmd = illegal_reg;
    assign power_down = pd_reg;
    assign self_refresh = sref_reg;
    assign odt_active = odt_reg;
    assign sr_refresh_tick = tick_reg;
    assign open_banks = open_reg;

endmodule : sdcsc_device

// File: rtl/sdcsc_if.sv
`timescale 1ns/1ps
interface sdcsc_if;
    logic clock_gate_input;
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic [1:0] group_select;
    logic [12:0] address;
    logic termination_enable;
    logic [15:0] data;
    logic data_strobe;
    logic [1:0] write_byte_mask;

    modport device_end (
        input clock_gate_input, chip_select_n, row_strobe_n, column_strobe_n,
        write_enable_n, group_select, address, termination_enable, data,
        data_strobe, write_byte_mask
    );
    modport ctrl_end (
        output clock_gate_input, chip_select_n, row_strobe_n, column_strobe_n,
        write_enable_n, group_select, address, termination_enable, data,
        data_strobe, write_byte_mask
    );
endinterface : sdcsc_if

// File: rtl/sdcsc_pkg.sv
package sdcsc_pkg;

    // ========================================
    // Geometry and timing
    localparam int SDCSC_CLK_KHZ = 10000;
    localparam int SDCSC_NUM_BANKS = 4;
    localparam int SDCSC_BANK_W = 2;
    localparam int SDCSC_ADDR_W = 13;
    localparam int SDCSC_DATA_W = 16;
    localparam int SDCSC_MASK_W = 2;
    localparam int SDCSC_AUTO_CLOSE_BIT = 10;
    localparam int SDCSC_BURST_LENGTH = 4;
    localparam int SDCSC_BURST_CLKS = SDCSC_BURST_LENGTH / 2;
    localparam int SDCSC_MIN_GATE_HOLD_CLKS = 3;
    localparam int SDCSC_XSRD_CLKS = 200;
    localparam int SDCSC_XSNR_NS = 2000;
    localparam int SDCSC_XSNR_CLKS = (SDCSC_XSNR_NS * SDCSC_CLK_KHZ + 999999) / 1000000;
    localparam int SDCSC_SR_TICK_CLKS = 64;
    localparam int SDCSC_CNT_W = 8;
    localparam logic SDCSC_CKE_RESET = 1'b1;

    // ========================================
    // Pin encodings of {row, column, write} strobes
    localparam logic [2:0] SDCSC_RCW_MRS = 3'h0;
    localparam logic [2:0] SDCSC_RCW_REF = 3'h1;
    localparam logic [2:0] SDCSC_RCW_PRE = 3'h2;
    localparam logic [2:0] SDCSC_RCW_ACT = 3'h3;
    localparam logic [2:0] SDCSC_RCW_WRITE = 3'h4;
    localparam logic [2:0] SDCSC_RCW_READ = 3'h5;
    localparam logic [2:0] SDCSC_RCW_NOP = 3'h7;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_READ, CMD_WRITE, CMD_REF, CMD_MRS,
        CMD_PD_ENTER, CMD_PD_EXIT, CMD_SR_ENTER, CMD_SR_EXIT, CMD_BAD
    } sdcsc_cmd_t;

    // ========================================
    // Command decode and legality with both gate samples high
    function automatic sdcsc_cmd_t sdcsc_decode(input logic cs_n, input logic [2:0] rcw);
        sdcsc_cmd_t c;
        c = CMD_BAD;
        if (cs_n) begin
            c = CMD_NOP;
        end else begin
            unique case (rcw)
                SDCSC_RCW_MRS: c = CMD_MRS;
                SDCSC_RCW_REF: c = CMD_REF;
                SDCSC_RCW_PRE: c = CMD_PRE;
                SDCSC_RCW_ACT: c = CMD_ACT;
                SDCSC_RCW_WRITE: c = CMD_WRITE;
                SDCSC_RCW_READ: c = CMD_READ;
                SDCSC_RCW_NOP: c = CMD_NOP;
                default: c = CMD_BAD;
            endcase
        end
        return c;
    endfunction : sdcsc_decode

    function automatic logic sdcsc_cmd_legal(input sdcsc_cmd_t c, input logic any_open,
                                             input logic in_read, input logic in_write);
        logic ok;
        ok = 1'b0;
        case (c)
            CMD_NOP: ok = 1'b1;
            CMD_ACT, CMD_REF, CMD_MRS: ok = !any_open && !in_read && !in_write;
            CMD_PRE: ok = !in_read && !in_write;
            CMD_READ: ok = any_open && !in_write;
            CMD_WRITE: ok = any_open && !in_read;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : sdcsc_cmd_legal

endpackage : sdcsc_pkg

// File: test/sdcsc_chk.sv
`timescale 1ns/1ps
module sdcsc_chk import sdcsc_pkg::*; (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clock_gate_input,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic data_strobe
);
    logic [2:0] rcw;
    logic nop;
    logic g;
    logic sr_reg;
    assign rcw = {row_strobe_n, column_strobe_n, write_enable_n};
    assign nop = chip_select_n || rcw == SDCSC_RCW_NOP;
    assign g = clock_gate_input;
    // Remembers a self refresh entry
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sr_reg <= 1'b0;
        end else if ($fell(g) && !nop) begin
            sr_reg <= 1'b1;
        end else if ($rose(g)) begin
            sr_reg <= 1'b0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    gate_hold_a: assert property ($changed(g) |=> $stable(g)[*2])
        else $error("gate changed too soon");
    entry_cmd_a: assert property ($fell(g) |-> nop || rcw == SDCSC_RCW_REF)
        else $error("bad command at gate fall");
    exit_cmd_a: assert property ($rose(g) |-> nop)
        else $error("bad command at gate rise");
    low_quiet_a: assert property (!g && !$fell(g) |-> nop)
        else $error("command while gate low");
    write_beats_a: assert property (g && !chip_select_n && rcw == SDCSC_RCW_WRITE
        |=> data_strobe[*2] ##1 !data_strobe)
        else $error("write beats wrong");
    burst_gap_a: assert property (!chip_select_n && rcw[2:1] == 2'h2 |=> nop[*2])
        else $error("burst interrupted");
    sr_quiet_a: assert property ($rose(g) && sr_reg |-> nop[*4])
        else $error("command in exit delay");
    sr_read_a: assert property ($rose(g) && sr_reg
        |-> (chip_select_n || rcw != SDCSC_RCW_READ)[*8])
        else $error("early read after exit");
endmodule : sdcsc_chk

// File: test/sdram_command_state_control_tb_top.sv
`timescale 1ns/1ps
module sdram_command_state_control_tb_top import sdcsc_pkg::*;;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic odt_level = 1'b0;
    logic calib_active = 1'b0;
    sdcsc_cmd_t req_cmd = CMD_NOP;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_addr = 13'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [3:0] req_wmask = 4'h0;
    logic req_ready, req_done, req_error, low_power, wr_valid, read_beat, illegal_cmd;
    logic power_down, self_refresh, odt_active, sr_refresh_tick;
    logic [15:0] wr_data;
    logic [1:0] wr_byte_en;
    logic [3:0] open_banks;
    int fail_count = 0;
    int compares = 0;
    int wv_n = 0;
    int rb_n = 0;
    int il_n = 0;
    int tk_n = 0;
    int t0;
    sdcsc_if pins_if();
    sdcsc_device #(.SR_TICK_CLKS(8)) sdcsc_device_i (.pins(pins_if), .*);
    sdcsc_ctrl #(.XSNR_CLKS(4), .XSRD_CLKS(8)) sdcsc_ctrl_i (.pins(pins_if), .*);
    sdcsc_chk sdcsc_chk_i (.ref_clk(ref_clk), .nrst(nrst),
        .clock_gate_input(pins_if.clock_gate_input), .chip_select_n(pins_if.chip_select_n),
        .row_strobe_n(pins_if.row_strobe_n), .column_strobe_n(pins_if.column_strobe_n),
        .write_enable_n(pins_if.write_enable_n), .data_strobe(pins_if.data_strobe));
    // ====
    // Clock, pulse counters, watchdog
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        wv_n += int'(wr_valid === 1'b1);
        rb_n += int'(read_beat === 1'b1);
        il_n += int'(illegal_cmd === 1'b1);
        tk_n += int'(sr_refresh_tick === 1'b1);
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
        compares++;
        if (v !== e) begin
            $display("BAD %s exp %h got %h", nm, e, v);
            fail_count++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic req(input sdcsc_cmd_t c, input logic [12:0] a, input logic err);
        int n;
        n = 0;
        tick(1);
        while (req_ready !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        req_valid = 1'b1;
        req_cmd = c;
        req_addr = a;
        tick(1);
        req_valid = 1'b0;
        chk("done", 16'(!err), 16'(req_done));
        chk("error", 16'(err), 16'(req_error));
    endtask : req
    task automatic t_cmds();
        req(CMD_READ, 13'h0, 1'b1);
        req(CMD_ACT, 13'h0, 1'b0);
        tick(2);
        chk("banks", 16'h1, 16'(open_banks));
        req(CMD_ACT, 13'h0, 1'b1);
        req(CMD_MRS, 13'h0, 1'b1);
        $display("test cmds done");
    endtask : t_cmds
    task automatic t_write();
        t0 = wv_n;
        req_wdata = 32'h5678_1234;
        req_wmask = 4'h4;
        req(CMD_WRITE, 13'h0, 1'b0);
        tick(2);
        chk("data0", 16'h1234, wr_data);
        chk("byte_en0", 16'h3, 16'(wr_byte_en));
        tick(1);
        chk("data", 16'h5678, wr_data);
        chk("byte_en", 16'h2, 16'(wr_byte_en));
        tick(2);
        chk("beats", 16'h2, 16'(wv_n - t0));
        t0 = rb_n;
        req(CMD_READ, 13'h0, 1'b0);
        tick(5);
        chk("reads", 16'(SDCSC_BURST_CLKS), 16'(rb_n - t0));
        $display("test write done");
    endtask : t_write
    task automatic t_pd();
        calib_active = 1'b1;
        req(CMD_PD_ENTER, 13'h0, 1'b1);
        calib_active = 1'b0;
        t0 = tk_n;
        req(CMD_PD_ENTER, 13'h0, 1'b0);
        tick(2);
        chk("pd", 16'h1, 16'(power_down));
        chk("low", 16'h1, 16'(low_power));
        tick(20);
        chk("ticks", 16'h0, 16'(tk_n - t0));
        req(CMD_PD_EXIT, 13'h0, 1'b0);
        tick(2);
        chk("pd_off", 16'h0, 16'(power_down));
        chk("banks_kept", 16'h1, 16'(open_banks));
        req(CMD_SR_ENTER, 13'h0, 1'b1);
        req(CMD_PRE, 13'h0400, 1'b0);
        tick(2);
        chk("closed", 16'h0, 16'(open_banks));
        req(CMD_REF, 13'h0, 1'b0);
        $display("test pd done");
    endtask : t_pd
    task automatic t_sr();
        odt_level = 1'b1;
        req(CMD_SR_ENTER, 13'h0, 1'b0);
        tick(2);
        chk("sr", 16'h1, 16'(self_refresh));
        chk("odt_sr", 16'h0, 16'(odt_active));
        t0 = tk_n;
        tick(16);
        chk("sr_ticks", 16'h2, 16'(tk_n - t0));
        req(CMD_SR_EXIT, 13'h0, 1'b0);
        tick(2);
        chk("sr_off", 16'h0, 16'(self_refresh));
        chk("odt_on", 16'h1, 16'(odt_active));
        req(CMD_ACT, 13'h0, 1'b0);
        req(CMD_READ, 13'h0, 1'b1);
        req(CMD_READ, 13'h0, 1'b0);
        tick(4);
        $display("test sr done");
    endtask : t_sr
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_cmds();
        t_write();
        t_pd();
        t_sr();
        chk("illegal", 16'h0, 16'(il_n));
        stop_test();
    end
endmodule : sdram_command_state_control_tb_top
